// File: verilog/sfpsc_pkg.sv
// Purpose: shared constants, types and helpers for the flash pin-state block
// Assumes: system clock of 200 MHz; link clock comes from the host
// Notes: lane 0 is serial input, lane 1 serial output, lane 3 hold or reset

// ----------------------------------------------------------------------
// package
// ----------------------------------------------------------------------
package sfpsc_pkg;

  // system clock period
  localparam int CLK_PERIOD_PS = 5000;

  // command framing
  localparam int INSTR_BITS = 8;
  localparam int MODE_BITS = 8;
  localparam int ADDR_BITS_3B = 24;
  localparam int ADDR_BITS_4B = 32;
  localparam int LAT_W = 5;
  localparam int LCNT_W = 6;

  // lane indices
  localparam int LANE_SI = 0;
  localparam int LANE_SO = 1;
  localparam int LANE_HOLD = 3;

  // output enable patterns per state
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_SO = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [3:0] OE_NO_L3 = 4'h7;
  localparam logic [3:0] OE_ALL = 4'hF;

  // synchroniser reset pattern {vcc_on, vcc_run, rst_pin_n, lane3, cs_n}
  localparam logic [4:0] SYNC_RST = 5'h07;

  // link-side interface states
  typedef enum logic [3:0] {
    LS_STBY, LS_INSTR, LS_SIN, LS_SLAT, LS_SOUT, LS_DIN, LS_DLAT,
    LS_DOUT, LS_QPPA, LS_QIN, LS_QLAT, LS_QOUT
  } sfpsc_lstate_t;

  // supply and reset states
  typedef enum logic [2:0] {
    SS_OFF, SS_PROT, SS_POR, SS_RDY, SS_WLOW, SS_WRST, SS_WREL
  } sfpsc_sstate_t;

  // transfer format of the pending command
  typedef enum logic [2:0] {
    FMT_ALONE, FMT_SWRITE, FMT_SREAD, FMT_DOUT, FMT_QOUT, FMT_DIO,
    FMT_QIO, FMT_QPP
  } sfpsc_fmt_t;

  typedef struct packed {
    sfpsc_fmt_t kind;
    logic addr4;
    logic [LAT_W-1:0] lat;
  } sfpsc_cmd_t;

  // lanes the device drives in a state
  function automatic logic [3:0] sfpsc_oe_of(input sfpsc_lstate_t s);
    case (s)
      LS_SOUT: return OE_SO;
      LS_DOUT: return OE_DUAL;
      LS_QOUT: return OE_QUAD;
      default: return OE_NONE;
    endcase
  endfunction

  // least time in ns to whole clock cycles, at least one
  function automatic int sfpsc_cycles(input int ns);
    longint c;
    c = (longint'(ns) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : int'(c);
  endfunction

endpackage

// File: verilog/sfpsc_xfer_if.sv
// Purpose: carrier for a word and its strobe between two modules
// Assumes: strobe and data are valid on the same source clock edge
// Notes: src drives, dst samples

// ----------------------------------------------------------------------
// interface
// ----------------------------------------------------------------------
interface sfpsc_xfer_if;
  logic [7:0] data;
  logic stb;
  modport src (output data, output stb);
  modport dst (input data, input stb);
endinterface

// File: verilog/sfpsc_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: each bit is an independent level
// Notes: first stage is read by the second stage only

// ----------------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------------
module sfpsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic i_clk,
  input logic i_rst_n,
  input logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two stages, synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule

// File: verilog/sfpsc_word_xfer.sv
// Purpose: carries a byte from the link clock to the system clock
// Assumes: at most one word per several system cycles
// Notes: toggle handshake; data held stable until the toggle lands

// ----------------------------------------------------------------------
// word crossing
// ----------------------------------------------------------------------
module sfpsc_word_xfer (
  input logic i_src_clk,
  input logic i_src_rst_n,
  sfpsc_xfer_if.dst i_x,
  input logic i_clk,
  input logic i_rst_n,
  input logic i_clr,
  output logic [7:0] o_data,
  output logic o_stb
);

  logic tog_r;
  logic [7:0] dat_r;
  logic tog_s;
  logic prev_r;
  logic [7:0] o_data_r;
  logic o_stb_r;

  // source side: flip toggle and hold word
  always_ff @(posedge i_src_clk or negedge i_src_rst_n)
  begin
    if (!i_src_rst_n)
    begin
      tog_r <= 1'b0;
      dat_r <= 8'h00;
    end
    else if (i_x.stb)
    begin
      tog_r <= ~tog_r;
      dat_r <= i_x.data;
    end
  end

  sfpsc_sync #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(tog_r),
    .o_q(tog_s)
  );

  // destination side: edge of the synced toggle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      prev_r <= 1'b0;
      o_stb_r <= 1'b0;
      o_data_r <= 8'h00;
    end
    else
    begin
      prev_r <= tog_s;
      o_stb_r <= (tog_s ^ prev_r) & ~i_clr;
      if ((tog_s ^ prev_r) && !i_clr)
        o_data_r <= dat_r;
    end
  end

  assign o_data = o_data_r;
  assign o_stb = o_stb_r;

endmodule

// File: verilog/sfpsc_top.sv
// Purpose: per-state pin ownership of a multi-lane serial flash port
// Assumes: host clocks the link in mode 0 or 3; command format given
//          by the device's decoder on i_cmd, steady while cs_n is low
// Notes: link logic runs on i_sck; supply and reset logic on i_clk
//
// Behaviour
// - power off or protection: serial output floats
// - dedicated reset low: warm reset, all floated
// - lane3 reset low starts warm reset, gated
// - instruction cycle: device drives no lane
// - single input cycles: serial output undriven
// - single latency: inputs ignored, outputs undriven
// - single output: device drives lane1
// - dual latency: lanes released for turnaround
// - dual output: device drives lanes 0, 1
// - quad latency: all lanes released
// - quad output: device drives all lanes, lane3 only if quad enabled
// - hold state exists when lane3 is pause
// - lane3 as reset: no hold state
// - cs high: standby, wait for cs fall
// - power-up interval: no response, no drive
// - pause low freezes state, floats outputs
// - lane3 is pause unless quad or lane3 reset enabled

// ----------------------------------------------------------------------
// top
// ----------------------------------------------------------------------
module sfpsc_top
  import sfpsc_pkg::*;
#(
  parameter int T_PU_NS = 1000,
  parameter int T_RP_NS = 200,
  parameter int T_RPH_NS = 500,
  parameter int T_RH_NS = 50,
  parameter int CNT_W = 24
) (
  input logic i_clk,
  input logic i_rst_n,
  input logic i_sck,
  input logic i_cs_n,
  input logic [3:0] i_lane_i,
  output logic [3:0] o_lane_o,
  output logic [3:0] o_lane_oe,
  input logic i_reset_pin_n,
  input logic i_vcc_on,
  input logic i_vcc_run,
  input logic i_sep_rst_en,
  input logic i_lane3_rst_en,
  input logic i_quad_en,
  input sfpsc_cmd_t i_cmd,
  input logic [7:0] i_rd_byte,
  output logic [7:0] o_instr,
  output logic o_instr_vld,
  output logic o_ready
);

  // --------------------------------------------------------------------
  // timing counts
  // --------------------------------------------------------------------
  localparam int CYC_PU = sfpsc_cycles(T_PU_NS);
  localparam int CYC_RP = sfpsc_cycles(T_RP_NS);
  localparam int CYC_RPH = sfpsc_cycles(T_RPH_NS);
  localparam int CYC_RH = sfpsc_cycles(T_RH_NS);
  localparam logic [CNT_W-1:0] CNT_PU = CNT_W'(CYC_PU - 1);
  localparam logic [CNT_W-1:0] CNT_RP = CNT_W'(CYC_RP - 1);
  localparam logic [CNT_W-1:0] CNT_RPH = CNT_W'(CYC_RPH - 1);
  localparam logic [CNT_W-1:0] CNT_RH = CNT_W'(CYC_RH - 1);

  // --------------------------------------------------------------------
  // system-side declarations
  // --------------------------------------------------------------------
  logic [4:0] pins_s;
  logic vcc_on_s;
  logic vcc_run_s;
  logic rst_pin_s;
  logic lane3_s;
  logic cs_s;
  logic warm_req;
  sfpsc_sstate_t sys_r;
  sfpsc_sstate_t sys_nxt;
  logic [CNT_W-1:0] scnt_r;
  logic [CNT_W-1:0] scnt_nxt;
  logic blk_r;
  logic ready_r;

  // --------------------------------------------------------------------
  // link-side declarations
  // --------------------------------------------------------------------
  logic link_rst_n;
  logic oe_rst_n;
  logic src_rst_n;
  logic hold_mode;
  logic hold_act;
  sfpsc_lstate_t state_r;
  sfpsc_lstate_t state_nxt;
  logic [LCNT_W-1:0] lcnt_r;
  sfpsc_cmd_t cmd_r;
  logic [7:0] rd_r;
  logic [7:0] ins_r;
  logic [7:0] ins_nxt;
  logic instr_done;
  logic [7:0] sh_r;
  logic [7:0] sh_src;
  logic run_r;
  logic [3:0] lane_o_r;
  logic [3:0] lane_oe_r;
  sfpsc_xfer_if ins_if ();

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------

  // read state that follows the address or latency of a format
  function automatic sfpsc_lstate_t out_of(input sfpsc_fmt_t k);
    case (k)
      FMT_QOUT, FMT_QIO: return LS_QOUT;
      FMT_DOUT, FMT_DIO: return LS_DOUT;
      default: return LS_SOUT;
    endcase
  endfunction

  // next interface state at the end of a phase
  function automatic sfpsc_lstate_t next_of(input sfpsc_lstate_t s,
                                            input sfpsc_cmd_t c);
    logic nolat;
    nolat = (c.lat == '0);
    case (s)
      LS_STBY: return LS_INSTR;
      LS_INSTR:
        case (c.kind)
          FMT_DIO: return LS_DIN;
          FMT_QIO: return LS_QIN;
          FMT_QPP: return LS_QPPA;
          default: return LS_SIN;
        endcase
      LS_SIN:
        if (c.kind == FMT_ALONE || c.kind == FMT_SWRITE)
          return LS_SIN;
        else
          return nolat ? out_of(c.kind) : LS_SLAT;
      LS_SLAT: return out_of(c.kind);
      LS_DIN: return nolat ? LS_DOUT : LS_DLAT;
      LS_DLAT: return LS_DOUT;
      LS_QPPA: return LS_QIN;
      LS_QIN:
        if (c.kind == FMT_QPP)
          return LS_QIN;
        else
          return nolat ? LS_QOUT : LS_QLAT;
      LS_QLAT: return LS_QOUT;
      default: return s;
    endcase
  endfunction

  // cycles in a phase, less one
  function automatic logic [LCNT_W-1:0] len_of(input sfpsc_lstate_t s,
                                               input sfpsc_cmd_t c);
    int abits;
    int n;
    abits = c.addr4 ? ADDR_BITS_4B : ADDR_BITS_3B;
    case (s)
      LS_INSTR: n = INSTR_BITS - 2;
      LS_SIN, LS_QPPA: n = abits - 1;
      LS_DIN: n = (abits + MODE_BITS) / 2 - 1;
      LS_QIN: n = (abits + MODE_BITS) / 4 - 1;
      LS_SLAT, LS_DLAT, LS_QLAT: n = int'(c.lat) - 1;
      default: n = 0;
    endcase
    return LCNT_W'(n);
  endfunction

  // lane levels for the leading bits of a byte
  function automatic logic [3:0] lanes_of(input sfpsc_lstate_t s,
                                          input logic [7:0] b);
    case (s)
      LS_SOUT: return {2'h0, b[7], 1'h0};
      LS_DOUT: return {2'h0, b[7:6]};
      LS_QOUT: return b[7:4];
      default: return 4'h0;
    endcase
  endfunction

  // byte rotated past the bits just sent
  function automatic logic [7:0] rot_of(input sfpsc_lstate_t s,
                                        input logic [7:0] b);
    case (s)
      LS_SOUT: return {b[6:0], b[7]};
      LS_DOUT: return {b[5:0], b[7:6]};
      LS_QOUT: return {b[3:0], b[7:4]};
      default: return b;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // supply and reset sequencing (system clock)
  // --------------------------------------------------------------------

  // pins into the system domain
  sfpsc_sync #(.W(5), .RST_VAL(SYNC_RST)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_vcc_on, i_vcc_run, i_reset_pin_n, i_lane_i[LANE_HOLD],
          i_cs_n}),
    .o_q(pins_s)
  );
  assign {vcc_on_s, vcc_run_s, rst_pin_s, lane3_s, cs_s} = pins_s;

  // warm reset request from either reset source
  assign warm_req = (i_sep_rst_en & ~rst_pin_s)
                  | (i_lane3_rst_en & ~lane3_s & (~i_quad_en | cs_s));

  // next supply state
  always_comb
  begin
    sys_nxt = sys_r;
    scnt_nxt = (scnt_r != '0) ? scnt_r - CNT_W'(1) : scnt_r;
    case (sys_r)
      SS_OFF:
        if (vcc_on_s)
        begin
          sys_nxt = SS_POR;
          scnt_nxt = CNT_PU;
        end
      SS_PROT:
        if (vcc_run_s)
          sys_nxt = SS_RDY;
      SS_POR:
        if (scnt_r == '0)
          sys_nxt = SS_RDY;
      SS_RDY:
        if (warm_req)
        begin
          sys_nxt = SS_WLOW;
          scnt_nxt = CNT_RP;
        end
      SS_WLOW:
        if (!warm_req)
          sys_nxt = SS_RDY;
        else if (scnt_r == '0)
        begin
          sys_nxt = SS_WRST;
          scnt_nxt = CNT_RPH;
        end
      SS_WRST:
        if (scnt_r == '0)
        begin
          sys_nxt = SS_WREL;
          scnt_nxt = CNT_RH;
        end
      SS_WREL:
        if (warm_req)
          scnt_nxt = CNT_RH;
        else if (scnt_r == '0)
          sys_nxt = SS_RDY;
      default: sys_nxt = SS_OFF;
    endcase
    // vcc_on loss overrides everything; vcc_run loss overrides every state except off and power-up
    if (!vcc_run_s && sys_r != SS_OFF && sys_r != SS_POR)
      sys_nxt = SS_PROT;
    if (!vcc_on_s)
      sys_nxt = SS_OFF;
  end

  // supply state registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sys_r <= SS_OFF;
      scnt_r <= '0;
      blk_r <= 1'b1;
      ready_r <= 1'b0;
    end
    else
    begin
      sys_r <= sys_nxt;
      scnt_r <= scnt_nxt;
      blk_r <= (sys_nxt != SS_RDY);
      ready_r <= (sys_nxt == SS_RDY);
    end
  end

  // --------------------------------------------------------------------
  // link state machine (link clock)
  // --------------------------------------------------------------------

  // frame reset: cs high or device blocked
  assign link_rst_n = ~i_cs_n & ~blk_r;
  assign src_rst_n = ~blk_r;
  // pause only when lane3 is neither data nor reset
  assign hold_mode = ~i_quad_en & ~i_lane3_rst_en;
  assign hold_act = hold_mode & ~i_lane_i[LANE_HOLD];
  assign oe_rst_n = link_rst_n & ~hold_act;
  assign state_nxt = next_of(state_r, cmd_r);

  // interface state, frozen while paused
  always_ff @(posedge i_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_r <= LS_STBY;
      lcnt_r <= '0;
    end
    else if (!hold_act)
    begin
      if (state_r == LS_STBY || lcnt_r == '0)
      begin
        state_r <= state_nxt;
        lcnt_r <= len_of(state_nxt, cmd_r);
      end
      else
        lcnt_r <= lcnt_r - LCNT_W'(1);
    end
  end

  // command snapshot taken at the first clock of a frame
  always_ff @(posedge i_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cmd_r <= '0;
      rd_r <= 8'h00;
    end
    else if (!hold_act && state_r == LS_STBY)
    begin
      cmd_r <= i_cmd;
      rd_r <= i_rd_byte;
    end
  end

  // instruction shift, msb first on lane 0
  assign ins_nxt = {ins_r[6:0], i_lane_i[LANE_SI]};
  assign instr_done = !hold_act && state_r == LS_INSTR && lcnt_r == '0;

  always_ff @(posedge i_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
      ins_r <= 8'h00;
    else if (!hold_act && (state_r == LS_STBY || state_r == LS_INSTR))
      ins_r <= ins_nxt;
  end

  // instruction byte to the system clock
  assign ins_if.data = ins_nxt;
  assign ins_if.stb = instr_done;

  sfpsc_word_xfer u_ins_xfer (
    .i_src_clk(i_sck),
    .i_src_rst_n(src_rst_n),
    .i_x(ins_if),
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(blk_r),
    .o_data(o_instr),
    .o_stb(o_instr_vld)
  );

  // --------------------------------------------------------------------
  // pin drive (falling edge of the link clock)
  // --------------------------------------------------------------------

  // enables follow the state; lane3 kept off unless quad enabled
  always_ff @(negedge i_sck or negedge oe_rst_n)
  begin
    if (!oe_rst_n)
      lane_oe_r <= OE_NONE;
    else
      lane_oe_r <= sfpsc_oe_of(state_r)
                 & (i_quad_en ? OE_ALL : OE_NO_L3);
  end

  // read data, rotating the snapshot byte
  assign sh_src = run_r ? sh_r : rd_r;

  always_ff @(negedge i_sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sh_r <= 8'h00;
      run_r <= 1'b0;
      lane_o_r <= 4'h0;
    end
    else if (!hold_act && sfpsc_oe_of(state_r) != OE_NONE)
    begin
      lane_o_r <= lanes_of(state_r, sh_src);
      sh_r <= rot_of(state_r, sh_src);
      run_r <= 1'b1;
    end
  end

  assign o_lane_o = lane_o_r;
  assign o_lane_oe = lane_oe_r;
  assign o_ready = ready_r;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_instr_body;
    (state_r == LS_INSTR) [*7];
  endsequence

  sequence s_instr_leave;
    s_instr_body ##1 (state_r != LS_INSTR);
  endsequence

  a_instr_length: assert property (
    @(posedge i_sck) disable iff (!link_rst_n || hold_act)
    (state_r == LS_STBY) |=> s_instr_leave)
    else $error("instruction phase length wrong");

  a_instr_quiet: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (state_r == LS_INSTR) |-> (lane_oe_r == OE_NONE))
    else $error("lane driven during instruction");

  a_input_quiet: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (state_r inside {LS_SIN, LS_SLAT, LS_DIN, LS_DLAT, LS_QPPA,
                     LS_QIN, LS_QLAT}) |-> (lane_oe_r == OE_NONE))
    else $error("lane driven in input or latency");

  a_single_drive: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (state_r == LS_SOUT && !hold_act && !$past(hold_act))
      |-> (lane_oe_r == OE_SO))
    else $error("serial output not driven");

  a_dual_drive: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (state_r == LS_DOUT && !hold_act && !$past(hold_act))
      |-> (lane_oe_r == OE_DUAL))
    else $error("dual lanes not driven");

  a_quad_drive: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (state_r == LS_QOUT && i_quad_en && !hold_act && !$past(hold_act))
      |-> (lane_oe_r == OE_QUAD))
    else $error("quad lanes not driven");

  a_hold_freeze: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    hold_act |-> (lane_oe_r == OE_NONE) ##1 $stable(state_r))
    else $error("state moved or lanes driven in hold");

  a_l3rst_nohold: assert property (
    @(posedge i_sck) disable iff (!link_rst_n)
    (i_lane3_rst_en && state_r == LS_STBY) |=> (state_r == LS_INSTR))
    else $error("frame paused with lane3 as reset");

  a_blk_floats: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    blk_r |-> (lane_oe_r == OE_NONE))
    else $error("lane driven while blocked");

  a_off_entry: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !vcc_on_s |=> (sys_r == SS_OFF) && blk_r && !ready_r)
    else $error("no power-off entry");

  a_por_silent: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (sys_r == SS_OFF && vcc_on_s) |=> (sys_r == SS_POR) && blk_r)
    else $error("power-up interval not silent");

  a_warm_enter: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (sys_r == SS_RDY && warm_req && vcc_run_s && vcc_on_s)
      |=> blk_r ##1 blk_r)
    else $error("warm reset did not block");

endmodule

// File: sim/sfpsc_host.sv
// Purpose: host controller model for the flash link, mode 0
// Assumes: 32 ns link clock, stopped low outside frames
// Notes: logs device enables and lane levels at each rising edge
// ----------------------------------------------------------------
// host model
// ----------------------------------------------------------------
module sfpsc_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_lane,
  output logic [3:0] o_oe,
  input logic [3:0] i_lane,
  input logic [3:0] i_dev_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] oe_q[$];
  logic [3:0] dat_q[$];
  // idle: deselected, clock parked low
  initial
  begin
    o_sck = 1'h0;
    o_cs_n = 1'h1;
    o_lane = 4'h0;
    o_oe = 4'h0;
  end
  // one link cycle, lanes set while clock low
  task automatic cyc(input logic [3:0] v, input logic [3:0] en);
    o_lane = v;
    o_oe = en;
    #16 o_sck = 1'h1;
    oe_q.push_back(i_dev_oe);
    dat_q.push_back(i_lane);
    #16 o_sck = 1'h0;
  endtask
  // instruction, address, latency and output or write data
  task automatic frame(input logic [7:0] ins, input int na,
    input logic [3:0] aen, input int lat, input int n,
    input logic [3:0] den);
    oe_q.delete();
    dat_q.delete();
    o_cs_n = 1'h0;
    for (int i = 7; i >= 0; i--) cyc({3'h0, ins[i]}, 4'h1);
    for (int i = 0; i < na; i++) cyc(4'(i) & aen, aen);
    for (int i = 0; i < lat + n; i++) cyc(4'h5 & den, den);
    #8 o_cs_n = 1'h1;
    o_oe = 4'h0;
    #40;
  endtask
endmodule

// File: sim/test_serial_flash_pin_state_control.sv
// Purpose: self-checking bench for the flash pin-state block
// Assumes: lanes pulled up; hold switch may pull lane3 low
// Notes: short reset timing parameters keep the run brief
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module test_serial_flash_pin_state_control
  import sfpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, sck, cs_n, vcc_on, quad_en, hold_low, rpin_n, vld, rdy;
  logic vcc_run, l3rst_en;
  logic [3:0] h_lane, h_oe, dev_o, dev_oe, lane;
  logic [7:0] rd, ins, ins_o, got_ins;
  sfpsc_cmd_t cmd;
  logic [31:0] lfsr = 32'h2B3DE257;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // wire levels: device, hold switch, host, pull-up
  always_comb
    for (int i = 0; i < 4; i++)
      lane[i] = dev_oe[i] ? dev_o[i] : (i == 3 && hold_low) ? 1'h0 :
        h_oe[i] ? h_lane[i] : 1'h1;
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  sfpsc_top #(.T_PU_NS(20), .T_RP_NS(20), .T_RPH_NS(20), .T_RH_NS(20))
    i_sfpsc_top (.i_clk(clk), .i_rst_n(rst_n), .i_sck(sck),
    .i_cs_n(cs_n), .i_lane_i(lane), .o_lane_o(dev_o), .o_lane_oe(dev_oe),
    .i_reset_pin_n(rpin_n), .i_vcc_on(vcc_on), .i_vcc_run(vcc_run),
    .i_sep_rst_en(1'h1), .i_lane3_rst_en(l3rst_en), .i_quad_en(quad_en),
    .i_cmd(cmd), .i_rd_byte(rd), .o_instr(ins_o), .o_instr_vld(vld),
    .o_ready(rdy));
  sfpsc_host i_sfpsc_host (.o_sck(sck), .o_cs_n(cs_n), .o_lane(h_lane),
    .o_oe(h_oe), .i_lane(lane), .i_dev_oe(dev_oe));
  // capture reported instruction; cut a hang short
  always @(posedge clk)
  begin
    if (vld === 1'h1) got_ins <= ins_o;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // lane levels of output cycle k, msb first, lane0 lowest
  function automatic logic [3:0] exp_dat(logic [7:0] b, int w, int k);
    logic [7:0] r;
    r = b >> (8 - w * (k % (8 / w) + 1));
    return w == 1 ? {2'h0, r[0], 1'h0} : w == 2 ? {2'h0, r[1:0]} : r[3:0];
  endfunction
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 300 && rdy !== 1'h1; i++) @(posedge clk);
    #1 chk("ready", 8'h1, 8'(rdy));
  endtask
  // read frame; enables checked at every cycle, lanes in output cycles
  task automatic rd_frame(sfpsc_fmt_t k, int w, logic [3:0] x, int lat,
    bit live);
    int na;
    int s0;
    logic [3:0] aen;
    lfsr = nxt(lfsr);
    ins = lfsr[7:0];
    rd = lfsr[15:8];
    // address cycles and lanes by transfer width
    na = k == FMT_DIO ? (ADDR_BITS_3B + MODE_BITS) / 2 :
      k == FMT_QIO ? (ADDR_BITS_3B + MODE_BITS) / 4 : ADDR_BITS_3B;
    aen = k == FMT_DIO ? 4'h3 : k == FMT_QIO ? 4'hF : 4'h1;
    s0 = INSTR_BITS + na + lat;
    cmd = '{kind: k, addr4: 1'h0, lat: 5'(lat)};
    i_sfpsc_host.frame(ins, na, aen, lat, 12,
      k == FMT_QPP ? 4'hF : 4'h0);
    for (int c = 0; c < s0 + 12; c++)
    begin
      chk("oe", 8'(live && c >= s0 ? x : 4'h0),
        8'(i_sfpsc_host.oe_q[c]));
      if (live && c >= s0 && x != 4'h0)
        chk("data", 8'(exp_dat(rd, w, c - s0) & x),
          8'(i_sfpsc_host.dat_q[c] & x));
    end
    chk("idle", 8'h0, 8'(dev_oe));
    if (live) chk("instr", ins, got_ins);
  endtask
  // main sequence
  initial
  begin
    {rst_n, quad_en, hold_low, l3rst_en, rd} = '0;
    {vcc_on, vcc_run, rpin_n} = 3'h7;
    cmd = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    wait_rdy();
    rd_frame(FMT_SREAD, 1, OE_SO, 0, 1);
    rd_frame(FMT_QOUT, 4, OE_NO_L3, 1, 1);
    quad_en = 1'h1;
    for (int r = 0; r < 8; r++)
      case (r % 4)
        0: rd_frame(FMT_DOUT, 2, OE_DUAL, int'(lfsr[18:16]), 1);
        1: rd_frame(FMT_QOUT, 4, OE_QUAD, int'(lfsr[18:16]), 1);
        2: rd_frame(FMT_DIO, 2, OE_DUAL, int'(lfsr[18:16]), 1);
        default: rd_frame(FMT_QIO, 4, OE_QUAD, int'(lfsr[18:16]), 1);
      endcase
    rd_frame(FMT_QPP, 4, OE_NONE, 0, 1);
    quad_en = 1'h0;
    // single read paused mid-output, pause spans one rising edge
    cmd = '{kind: FMT_SREAD, addr4: 1'h0, lat: 5'h00};
    fork
      i_sfpsc_host.frame(8'h3C, ADDR_BITS_3B, 4'h1, 0, 8, 4'h0);
      begin
        #1210 hold_low = 1'h1;
        #5 chk("hold", 8'h0, 8'(dev_oe));
        #25 hold_low = 1'h0;
        #30 chk("resume", 8'(OE_SO), 8'(dev_oe));
      end
    join
    // power off, protection, dedicated reset, lane3 reset
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk) #1;
      case (k)
        0: vcc_on = 1'h0;
        1: vcc_run = 1'h0;
        2: rpin_n = 1'h0;
        default: {l3rst_en, hold_low} = 2'h3;
      endcase
      repeat (20) @(posedge clk);
      #1 chk("ready", 8'h0, 8'(rdy));
      rd_frame(FMT_SREAD, 1, OE_SO, 0, 0);
      @(posedge clk) #1;
      {vcc_on, vcc_run, rpin_n, hold_low} = 4'hE;
      repeat (3) @(posedge clk);
      #1 chk("por", 8'(k == 1), 8'(rdy));
      wait_rdy();
    end
    rd_frame(FMT_SREAD, 1, OE_SO, 0, 1);
    end_sim();
  end
endmodule
